/* logic/adc_result_params.svh */
// constants for the converter result formatter and window detector
// assumes inclusion by bare name from the package and modules below
`ifndef ADC_RESULT_PARAMS_SVH
`define ADC_RESULT_PARAMS_SVH

// register index on the 4-bit register port
`define ADDR_CONTROL       4'h0
`define ADDR_RESULT_HIGH   4'h1
`define ADDR_RESULT_LOW    4'h2
`define ADDR_UPPER_HIGH    4'h3
`define ADDR_UPPER_LOW     4'h4
`define ADDR_LOWER_HIGH    4'h5
`define ADDR_LOWER_LOW     4'h6
`define ADDR_SAR_CONFIG    4'h7
`define ADDR_IRQ_STATUS    4'h8
`define ADDR_IRQ_CLEAR     4'h9
`define ADDR_IRQ_ENABLE    4'hA

// converter_control bit positions
`define CTL_ENABLE         7
`define CTL_TRACK_MODE     6
`define CTL_DONE_FLAG      5
`define CTL_BUSY           4
`define CTL_START_HI       3
`define CTL_START_LO       2
`define CTL_WINDOW_FLAG    1
`define CTL_LEFT_JUSTIFY   0

// sar_config fields
`define CFG_DIV_MSB        7
`define CFG_DIV_LSB        3
`define CFG_DIFFERENTIAL   0

// interrupt status, clear and enable bit positions
`define IRQ_DONE           0
`define IRQ_WINDOW         1

// reset values
`define RESET_CONTROL      8'h00
`define RESET_RESULT       8'h00
`define RESET_DIVIDER      5'h1F
`define RESET_UPPER_LIMIT  16'hFFFF
`define RESET_LOWER_LIMIT  16'h0000
`define RESET_IRQ_ENABLE   2'h0

// sequence lengths in sar clock periods
`define TRACK_SAR_CLOCKS   5'h03
`define CONVERT_SAR_CLOCKS 5'h10

`endif

/* logic/adc_result_pkg.sv */
// types shared by the converter sequencer and the result block
// assumes the params header sits beside it in logic/
`default_nettype none
`include "adc_result_params.svh"

package adc_result_pkg;

  // one-hot sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE    = 3'b001,
    SEQ_TRACK   = 3'b010,
    SEQ_CONVERT = 3'b100
  } seq_state_t;

  // start-of-conversion source select
  typedef enum logic [1:0] {
    START_ON_WRITE  = 2'b00,
    START_ON_TIMER3 = 2'b01,
    START_ON_PIN    = 2'b10,
    START_ON_TIMER2 = 2'b11
  } start_mode_t;

endpackage : adc_result_pkg

`default_nettype wire

/* logic/adc_result_window.sv */
// converter control, result formatting and window detector
// assumes register port masters obey one-cycle strobes; pins are synchronous
`timescale 1ns/100ps
`default_nettype none
`include "adc_result_params.svh"

module adc_result_window
  import adc_result_pkg::*;
(
  // clock, reset, freeze
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // start sources
  input  wire logic       timer3_overflow,
  input  wire logic       timer2_overflow,
  input  wire logic       external_convert_start_pin,
  // analog core
  input  wire logic [9:0] analog_code,
  output logic            sar_tick,
  output logic            track_active,
  output logic            hold_active,
  // interrupt
  output logic            irq
);

  //////////////////////////////////////////////////////////////////////
  // helper functions

  // place a raw code in the data register layout
  function automatic logic [15:0] format_word(input logic [9:0] code,
                                              input logic       left,
                                              input logic       diff);
    logic sign_fill;
    sign_fill = diff & code[9];
    if (left) begin
      format_word = {code, 6'b00_0000};
    end else begin
      format_word = {{6{sign_fill}}, code};
    end
  endfunction : format_word

  // a greater than b, signed when the data is differential
  function automatic logic above(input logic [15:0] a,
                                 input logic [15:0] b,
                                 input logic        diff);
    if (diff) begin
      above = $signed(a) > $signed(b);
    end else begin
      above = a > b;
    end
  endfunction : above

  //////////////////////////////////////////////////////////////////////
  // storage
  logic        enable_reg;
  logic        track_mode_reg;
  logic [1:0]  start_sel_reg;
  logic        left_justify_reg;
  logic        done_flag_reg;
  logic        window_flag_reg;
  logic [4:0]  divider_reg;
  logic        differential_reg;
  logic [7:0]  result_high_reg;
  logic [7:0]  result_low_reg;
  logic [15:0] upper_limit_reg;
  logic [15:0] lower_limit_reg;
  logic [1:0]  irq_enable_reg;
  logic        pin_prev_reg;

  // decoded strobes and events
  logic        wr_control;
  logic        wr_clear;
  logic        start_event;
  logic        pin_rise;
  logic        seq_busy;
  logic        seq_tracking;
  logic        seq_converting;
  logic        seq_done;
  logic        start_track;
  logic        start_convert;
  logic [15:0] word_now;
  logic        gt_hit;
  logic        lt_hit;
  logic        window_hit;
  start_mode_t start_mode;

  assign wr_control = reg_wr && (reg_addr == `ADDR_CONTROL);
  assign wr_clear   = reg_wr && (reg_addr == `ADDR_IRQ_CLEAR);
  assign start_mode = start_mode_t'(start_sel_reg);

  //////////////////////////////////////////////////////////////////////
  // control register fields written by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_reg       <= 1'(`RESET_CONTROL >> `CTL_ENABLE);
      track_mode_reg   <= 1'b0;
      start_sel_reg    <= 2'b00;
      left_justify_reg <= 1'b0;
    end else if (ce && wr_control) begin
      enable_reg       <= reg_wdata[`CTL_ENABLE];
      track_mode_reg   <= reg_wdata[`CTL_TRACK_MODE];
      start_sel_reg    <= reg_wdata[`CTL_START_HI:`CTL_START_LO];
      left_justify_reg <= reg_wdata[`CTL_LEFT_JUSTIFY];
    end
  end

  // divider and input type
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divider_reg      <= `RESET_DIVIDER;
      differential_reg <= 1'b0;
    end else if (ce && reg_wr && reg_addr == `ADDR_SAR_CONFIG) begin
      divider_reg      <= reg_wdata[`CFG_DIV_MSB:`CFG_DIV_LSB];
      differential_reg <= reg_wdata[`CFG_DIFFERENTIAL];
    end
  end

  // limit bytes, each loaded on its own
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      upper_limit_reg <= `RESET_UPPER_LIMIT;
      lower_limit_reg <= `RESET_LOWER_LIMIT;
    end else if (ce && reg_wr) begin
      unique case (reg_addr)
        `ADDR_UPPER_HIGH: upper_limit_reg[15:8] <= reg_wdata;
        `ADDR_UPPER_LOW:  upper_limit_reg[7:0]  <= reg_wdata;
        `ADDR_LOWER_HIGH: lower_limit_reg[15:8] <= reg_wdata;
        `ADDR_LOWER_LOW:  lower_limit_reg[7:0]  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // interrupt enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enable_reg <= `RESET_IRQ_ENABLE;
    end else if (ce && reg_wr && reg_addr == `ADDR_IRQ_ENABLE) begin
      irq_enable_reg <= reg_wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // start-of-conversion selection

  // pin edge detect; the pin is already synchronous
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_prev_reg <= 1'b1;
    end else if (ce) begin
      pin_prev_reg <= external_convert_start_pin;
    end
  end

  assign pin_rise = external_convert_start_pin && !pin_prev_reg;

  always_comb begin
    unique case (start_mode)
      START_ON_WRITE:  start_event = wr_control && reg_wdata[`CTL_BUSY];
      START_ON_TIMER3: start_event = timer3_overflow;
      START_ON_PIN:    start_event = pin_rise;
      START_ON_TIMER2: start_event = timer2_overflow;
    endcase
  end

  // with tracking mode clear the input tracks until the start event
  assign start_convert = enable_reg && !seq_busy && start_event &&
                         (!track_mode_reg || start_mode == START_ON_PIN);
  assign start_track   = enable_reg && !seq_busy && start_event &&
                         track_mode_reg && start_mode != START_ON_PIN;

  conversion_sequencer u_seq (
    .clk           (clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .divider       (divider_reg),
    .enable        (enable_reg),
    .start_track   (start_track),
    .start_convert (start_convert),
    .sar_tick      (sar_tick),
    .tracking      (seq_tracking),
    .converting    (seq_converting),
    .busy          (seq_busy),
    .done          (seq_done)
  );

  // analog track and hold commands
  always_comb begin
    if (!enable_reg) begin
      track_active = 1'b0;
    end else if (!track_mode_reg) begin
      track_active = !seq_converting;
    end else if (start_mode == START_ON_PIN) begin
      track_active = !seq_busy && !external_convert_start_pin;
    end else begin
      track_active = seq_tracking;
    end
  end

  assign hold_active = seq_converting;

  //////////////////////////////////////////////////////////////////////
  // result formatting and window compare
  assign word_now   = format_word(analog_code, left_justify_reg, differential_reg);
  assign gt_hit     = above(word_now, upper_limit_reg, differential_reg);
  assign lt_hit     = above(lower_limit_reg, word_now, differential_reg);

  // lower above upper: inside window; otherwise outside
  assign window_hit = above(lower_limit_reg, upper_limit_reg, differential_reg) ?
                      (gt_hit && lt_hit) : (gt_hit || lt_hit);

  // result bytes; a finished conversion beats a software write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_high_reg <= `RESET_RESULT;
      result_low_reg  <= `RESET_RESULT;
    end else if (ce) begin
      if (seq_done) begin
        result_high_reg <= word_now[15:8];
        result_low_reg  <= word_now[7:0];
      end else if (reg_wr && reg_addr == `ADDR_RESULT_HIGH) begin
        result_high_reg <= reg_wdata;
      end else if (reg_wr && reg_addr == `ADDR_RESULT_LOW) begin
        result_low_reg  <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sticky flags: hardware set wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_flag_reg <= 1'b0;
    end else if (ce) begin
      if (seq_done) begin
        done_flag_reg <= 1'b1;
      end else if (wr_clear && reg_wdata[`IRQ_DONE]) begin
        done_flag_reg <= 1'b0;
      end else if (wr_control) begin
        done_flag_reg <= reg_wdata[`CTL_DONE_FLAG];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      window_flag_reg <= 1'b0;
    end else if (ce) begin
      if (seq_done && window_hit) begin
        window_flag_reg <= 1'b1;
      end else if (wr_clear && reg_wdata[`IRQ_WINDOW]) begin
        window_flag_reg <= 1'b0;
      end else if (wr_control) begin
        window_flag_reg <= reg_wdata[`CTL_WINDOW_FLAG];
      end
    end
  end

  // level interrupt from enabled flags
  assign irq = (done_flag_reg && irq_enable_reg[`IRQ_DONE]) ||
               (window_flag_reg && irq_enable_reg[`IRQ_WINDOW]);

  //////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (!reg_rd) begin
        reg_rdata <= 8'h00;
      end else begin
        unique case (reg_addr)
          `ADDR_CONTROL:     reg_rdata <= {enable_reg, track_mode_reg, done_flag_reg, seq_busy,
                                           start_sel_reg, window_flag_reg, left_justify_reg};
          `ADDR_RESULT_HIGH: reg_rdata <= result_high_reg;
          `ADDR_RESULT_LOW:  reg_rdata <= result_low_reg;
          `ADDR_UPPER_HIGH:  reg_rdata <= upper_limit_reg[15:8];
          `ADDR_UPPER_LOW:   reg_rdata <= upper_limit_reg[7:0];
          `ADDR_LOWER_HIGH:  reg_rdata <= lower_limit_reg[15:8];
          `ADDR_LOWER_LOW:   reg_rdata <= lower_limit_reg[7:0];
          `ADDR_SAR_CONFIG:  reg_rdata <= {divider_reg, 2'b00, differential_reg};
          `ADDR_IRQ_STATUS:  reg_rdata <= {6'b00_0000, window_flag_reg, done_flag_reg};
          `ADDR_IRQ_ENABLE:  reg_rdata <= {6'b00_0000, irq_enable_reg};
          default:           reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule : adc_result_window

`default_nettype wire

/* logic/conversion_sequencer.sv */
// sar clock divider and track/convert sequencer
// assumes one clock, synchronous active-low reset and a freeze enable
`timescale 1ns/100ps
`default_nettype none
`include "adc_result_params.svh"

module conversion_sequencer
  import adc_result_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // control from the register side
  input  wire logic [4:0] divider,
  input  wire logic       enable,
  input  wire logic       start_track,
  input  wire logic       start_convert,
  // status
  output logic            sar_tick,
  output logic            tracking,
  output logic            converting,
  output logic            busy,
  output logic            done
);

  seq_state_t state_reg;
  logic [4:0] div_count_reg;
  logic [4:0] sar_count_reg;

  //////////////////////////////////////////////////////////////////////
  // sar clock: one tick every divider+1 system clocks while active
  assign sar_tick   = (state_reg != SEQ_IDLE) && (div_count_reg == divider);
  assign tracking   = (state_reg == SEQ_TRACK);
  assign converting = (state_reg == SEQ_CONVERT);
  assign busy       = (state_reg != SEQ_IDLE);

  // divider restarts with each sequence so the first period is whole
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_count_reg <= 5'h00;
    end else if (ce) begin
      if (state_reg == SEQ_IDLE || sar_tick) begin
        div_count_reg <= 5'h00;
      end else begin
        div_count_reg <= div_count_reg + 5'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state and sar period counter; disable aborts without a result
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= SEQ_IDLE;
      sar_count_reg <= 5'h00;
    end else if (ce) begin
      if (!enable) begin
        state_reg     <= SEQ_IDLE;
        sar_count_reg <= 5'h00;
      end else begin
        unique case (state_reg)
          SEQ_IDLE: begin
            sar_count_reg <= 5'h00;
            if (start_convert) begin
              state_reg <= SEQ_CONVERT;
            end else if (start_track) begin
              state_reg <= SEQ_TRACK;
            end
          end
          SEQ_TRACK: begin
            if (sar_tick) begin
              if (sar_count_reg == `TRACK_SAR_CLOCKS - 5'h01) begin
                state_reg     <= SEQ_CONVERT;
                sar_count_reg <= 5'h00;
              end else begin
                sar_count_reg <= sar_count_reg + 5'h01;
              end
            end
          end
          SEQ_CONVERT: begin
            if (sar_tick) begin
              if (sar_count_reg == `CONVERT_SAR_CLOCKS - 5'h01) begin
                state_reg     <= SEQ_IDLE;
                sar_count_reg <= 5'h00;
              end else begin
                sar_count_reg <= sar_count_reg + 5'h01;
              end
            end
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // end-of-conversion pulse, one cycle after the last sar period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= enable && converting && sar_tick &&
              (sar_count_reg == `CONVERT_SAR_CLOCKS - 5'h01);
    end
  end

endmodule : conversion_sequencer

`default_nettype wire

/* test/adc_result_window_asserts.sv */
// port checker for the result formatter and window detector
// assumes ce never low across a read, and the register map of the params header
`timescale 1ns/100ps
`default_nettype none
`include "adc_result_params.svh"

module adc_result_window_asserts (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // analog core and interrupt
  input wire logic       sar_tick,
  input wire logic       track_active,
  input wire logic       hold_active,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // sar ticks seen in the current hold phase
  logic [5:0] tick_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || !hold_active)
      tick_cnt <= 6'h00;
    else
      tick_cnt <= tick_cnt + {5'h00, sar_tick};
  end

  ////////////////////////////////////////////////////////////////////////
  // sequences and properties
  sequence s_conv_end;
    hold_active ##1 !hold_active;
  endsequence
  sequence s_dead_read;
    reg_rd && (reg_addr > `ADDR_IRQ_ENABLE || reg_addr == `ADDR_IRQ_CLEAR);
  endsequence
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  property p_dead_read;
    s_dead_read |=> reg_rdata == 8'h00;
  endproperty
  property p_tick_phase;
    sar_tick |-> hold_active || track_active;
  endproperty
  property p_phase_excl;
    !(hold_active && track_active);
  endproperty
  property p_reset_quiet;
    $rose(rst_n) |-> !irq && !hold_active && !sar_tick;
  endproperty
  property p_irq_clear;
    reg_wr && reg_addr == `ADDR_IRQ_CLEAR && reg_wdata == 8'h03 && !hold_active
      && !$past(hold_active) && !$past(hold_active, 2) |=> !irq;
  endproperty
  property p_hold_len;
    s_conv_end |-> tick_cnt == 6'h10 || $past(reg_wr);
  endproperty
  property p_irq_rise;
    $rose(irq) |-> $past(reg_wr) || $past(hold_active, 2) || $past(hold_active, 3);
  endproperty

  a_rdata_idle:  assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_dead_read:   assert property (p_dead_read) else $error("unmapped or clear read not zero");
  a_tick_phase:  assert property (p_tick_phase) else $error("sar tick outside a phase");
  a_phase_excl:  assert property (p_phase_excl) else $error("track and hold together");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  a_irq_clear:   assert property (p_irq_clear) else $error("irq stays after clear");
  a_hold_len:    assert property (p_hold_len) else $error("conversion tick count wrong");
  a_irq_rise:    assert property (p_irq_rise) else $error("irq rose without cause");
endmodule : adc_result_window_asserts

bind adc_result_window adc_result_window_asserts adc_result_window_asserts_i (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .sar_tick, .track_active, .hold_active, .irq);

`default_nettype wire

/* test/tb_adc_result_window.sv */
// self-checking bench for the result formatter and window detector
// assumes the design in logic/, the checker bound to it, 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "adc_result_params.svh"

module tb_adc_result_window;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic       timer3_overflow = 1'b0, timer2_overflow = 1'b0;
  logic       external_convert_start_pin = 1'b1;
  logic [9:0] analog_code = 10'h000;
  wire  [7:0] reg_rdata;
  wire        sar_tick, track_active, hold_active, irq;
  int         fail_count = 0, comparisons = 0;

  adc_result_window adc_result_window_i (
    .clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .timer3_overflow, .timer2_overflow, .external_convert_start_pin, .analog_code,
    .sar_tick, .track_active, .hold_active, .irq);

  // 50 ns clock
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string name, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string name);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    check(name, {8'h00, reg_rdata}, {8'h00, e});
  endtask : rd

  // both limits, high byte then low byte
  task automatic lim(input logic [15:0] up, lo);
    wr(`ADDR_UPPER_HIGH, up[15:8]);
    wr(`ADDR_UPPER_LOW, up[7:0]);
    wr(`ADDR_LOWER_HIGH, lo[15:8]);
    wr(`ADDR_LOWER_LOW, lo[7:0]);
  endtask : lim

  task automatic conv(input logic [9:0] code, input logic [7:0] ctl);
    @(posedge clk);
    analog_code <= code;
    // a start write acts on the enable and mode already held, so set them first
    wr(`ADDR_CONTROL, ctl & 8'hEF);
    wr(`ADDR_CONTROL, ctl);
    repeat (20) @(posedge clk);
  endtask : conv

  task automatic ck_irq(input logic e);
    @(negedge clk);
    check("irq", {15'h0000, irq}, {15'h0000, e});
  endtask : ck_irq

  task automatic count(input int n, output int trk, hld, tks);
    trk = 0;
    hld = 0;
    tks = 0;
    repeat (n) begin
      @(negedge clk);
      trk += int'(track_active === 1'b1);
      hld += int'(hold_active === 1'b1);
      tks += int'(sar_tick === 1'b1 && hold_active === 1'b1);
    end
  endtask : count

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rd(`ADDR_CONTROL, 8'h00, "control");
    rd(`ADDR_RESULT_HIGH, 8'h00, "result high");
    rd(`ADDR_SAR_CONFIG, 8'hF8, "sar config");
    rd(`ADDR_UPPER_LOW, 8'hFF, "upper low");
    rd(`ADDR_LOWER_HIGH, 8'h00, "lower high");
    rd(`ADDR_IRQ_ENABLE, 8'h00, "irq enable");
    wr(4'hF, 8'h5A);
    rd(4'hF, 8'h00, "unmapped");
    rd(`ADDR_IRQ_CLEAR, 8'h00, "irq clear");
    $display("test reset done");
  endtask : t_reset

  task automatic t_format;
    logic [15:0] w;
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_SAR_CONFIG, {7'h00, i[1]});
      conv(10'h2C5, 8'h90 | {7'h00, i[0]});
      w = i[0] ? {10'h2C5, 6'h00} : {{6{i[1]}}, 10'h2C5};
      rd(`ADDR_RESULT_HIGH, w[15:8], "result high");
      rd(`ADDR_RESULT_LOW, w[7:0], "result low");
      rd(`ADDR_CONTROL, 8'hA0 | {7'h00, i[0]}, "control");
    end
    $display("test format done");
  endtask : t_format

  task automatic t_window;
    wr(`ADDR_SAR_CONFIG, 8'h00);
    wr(`ADDR_IRQ_ENABLE, 8'h02);
    lim(16'h0080, 16'h0200);
    conv(10'h100, 8'h90);
    ck_irq(1'b1);
    rd(`ADDR_IRQ_STATUS, 8'h03, "status");
    rd(`ADDR_CONTROL, 8'hA2, "control");
    wr(`ADDR_IRQ_CLEAR, 8'h02);
    ck_irq(1'b0);
    rd(`ADDR_IRQ_STATUS, 8'h01, "status");
    lim(16'h0200, 16'h0080);
    conv(10'h100, 8'h90);
    rd(`ADDR_IRQ_STATUS, 8'h01, "status");
    ck_irq(1'b0);
    conv(10'h300, 8'h90);
    rd(`ADDR_IRQ_STATUS, 8'h03, "status");
    wr(`ADDR_IRQ_CLEAR, 8'h03);
    ck_irq(1'b0);
    $display("test window done");
  endtask : t_window

  task automatic t_signed;
    wr(`ADDR_SAR_CONFIG, 8'h01);
    lim(16'h0010, 16'hFFF0);
    conv(10'h3FF, 8'h90);
    rd(`ADDR_IRQ_STATUS, 8'h01, "status");
    conv(10'h3E0, 8'h90);
    rd(`ADDR_IRQ_STATUS, 8'h03, "status");
    $display("test signed done");
  endtask : t_signed

  task automatic t_divider;
    int trk, hld, tks;
    wr(`ADDR_SAR_CONFIG, 8'h10);
    wr(`ADDR_CONTROL, 8'h90);
    count(70, trk, hld, tks);
    check("hold cycles", hld[15:0], 16'h0030);
    check("sar ticks", tks[15:0], 16'h0010);
    rd(`ADDR_CONTROL, 8'hA2, "control");
    $display("test divider done");
  endtask : t_divider

  task automatic t_modes;
    int trk, hld, tks;
    wr(`ADDR_SAR_CONFIG, 8'h00);
    for (int m = 1; m < 4; m++) begin
      wr(`ADDR_CONTROL, 8'h80 | {4'h0, m[1:0], 2'b00});
      @(posedge clk);
      case (m)
        1: timer3_overflow <= 1'b1;
        2: external_convert_start_pin <= 1'b0;
        default: timer2_overflow <= 1'b1;
      endcase
      @(posedge clk);
      timer3_overflow <= 1'b0;
      timer2_overflow <= 1'b0;
      external_convert_start_pin <= 1'b1;
      count(25, trk, hld, tks);
      check("hold cycles", hld[15:0], 16'h0010);
      rd(`ADDR_CONTROL, 8'hA2 | {4'h0, m[1:0], 2'b00}, "control");
    end
    wr(`ADDR_CONTROL, 8'hC0);
    wr(`ADDR_CONTROL, 8'hD0);
    count(25, trk, hld, tks);
    check("track cycles", trk[15:0], 16'h0003);
    check("hold cycles", hld[15:0], 16'h0010);
    rd(`ADDR_CONTROL, 8'hE2, "control");
    // tracking mode with pin start: track while low, convert on the rise
    wr(`ADDR_CONTROL, 8'hC8);
    external_convert_start_pin <= 1'b0;
    count(4, trk, hld, tks);
    check("track cycles", trk[15:0], 16'h0004);
    @(posedge clk);
    external_convert_start_pin <= 1'b1;
    count(25, trk, hld, tks);
    check("hold cycles", hld[15:0], 16'h0010);
    rd(`ADDR_CONTROL, 8'hEA, "control");
    $display("test modes done");
  endtask : t_modes

  // a write while ce is low must leave the limit untouched
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    wr(`ADDR_UPPER_LOW, 8'h12);
    ce <= 1'b1;
    rd(`ADDR_UPPER_LOW, 8'h10, "frozen limit");
    $display("test freeze done");
  endtask : t_freeze

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_format;
    t_window;
    t_signed;
    t_divider;
    t_modes;
    t_freeze;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected end seen hang");
    close_out;
  end
endmodule : tb_adc_result_window

`default_nettype wire
